// file: rtl/rfps_decoder_defs.vh
`ifndef RFPS_DECODER_DEFS_VH
`define RFPS_DECODER_DEFS_VH

// Register byte offsets on the register bus.
`define RFPS_OFF_CMD_BYTE     5'h00
`define RFPS_OFF_RESPONSE     5'h04
`define RFPS_OFF_STATUS       5'h08
`define RFPS_OFF_DELAY_LO     5'h0c
`define RFPS_OFF_DELAY_HI     5'h10
`define RFPS_OFF_GUARD        5'h14
`define RFPS_OFF_SYNC         5'h18

// Command framing.
`define RFPS_CMD_SELECT       8'h02
`define RFPS_MAX_DATA         8'h09

// Protocol codes carried in the first data byte.
`define RFPS_PROTO_OFF        8'h00
`define RFPS_PROTO_VIC        8'h01
`define RFPS_PROTO_TYPEA      8'h02
`define RFPS_PROTO_TYPEB      8'h03

// Answer codes.
`define RFPS_RES_OK           8'h00
`define RFPS_RES_BAD_LEN      8'h82
`define RFPS_RES_BAD_PROTO    8'h83

// Vicinity parameter byte fields.
`define RFPS_VIC_RATE_HI      5
`define RFPS_VIC_RATE_LO      4
`define RFPS_VIC_SOF_BIT      3
`define RFPS_VIC_MOD_BIT      2
`define RFPS_VIC_SUB_BIT      1
`define RFPS_CRC_BIT          0

// Proximity parameter byte fields.
`define RFPS_TX_RATE_HI       7
`define RFPS_TX_RATE_LO       6
`define RFPS_RX_RATE_HI       5
`define RFPS_RX_RATE_LO       4

// Timing limits and defaults.
`define RFPS_EXP_MAX          8'h0e
`define RFPS_OFFSET_MAX       8'h7f
`define RFPS_OFFSET_BIAS      9'h080
`define RFPS_PERIOD_SHIFT     5'h05
`define RFPS_GUARD_DEFAULT    16'h03ff
`define RFPS_MIN_SYNC_DEFAULT 8'h00
`define RFPS_MAX_SYNC_DEFAULT 8'h1a

// Default Type A frame delay, in carrier periods (about 86 us).
`define RFPS_FDT_DEFAULT_FC   36'h000000494
// Vicinity fixed reply delay: 312 us, as carrier periods at 13.56 MHz.
`define RFPS_VIC_DELAY_US     312
`define RFPS_CARRIER_KHZ      13560
// Whole periods of 312 * 13560 / 1000, rounded down, sized to the delay width.
`define RFPS_VIC_DELAY_FC     36'h000001086

// Reset values of the stored command bytes and of the applied delay.
`define RFPS_RST_BYTE         8'h00
`define RFPS_RST_DELAY        36'h000000000

`endif

// file: rtl/rfps_delay_calc.v
`timescale 1ns/1ps
`include "rfps_decoder_defs.vh"

// Turns exponent, mantissa and offset into a delay in carrier periods:
// 2^exponent * (mantissa + 1) * (offset + 128) * 32, registered once.
module rfps_delay_calc #(
  parameter OUT_W = 36  // Width of the carrier period count.
) (
  // Clock and reset.
  input  wire             clock,
  input  wire             sys_rst,
  // Timing bytes.
  input  wire [7:0]       timingExponent,
  input  wire [7:0]       timingMantissa,
  input  wire [7:0]       timingOffset,
  // Result in carrier periods.
  output reg  [OUT_W-1:0] delayPeriods
);

  wire [8:0]       mantPlusOne;  // Mantissa plus one, up to 256.
  wire [8:0]       offPlusBias;  // Offset plus 128, up to 255 for legal offsets.
  wire [17:0]      product;      // Product of the two factors.
  wire [4:0]       shiftBy;      // Exponent plus 5, the shift for the fixed factor of 32.

  assign mantPlusOne = {1'b0, timingMantissa} + 9'h001;
  assign offPlusBias = {1'b0, timingOffset} + `RFPS_OFFSET_BIAS;
  assign product     = mantPlusOne * offPlusBias;
  assign shiftBy     = timingExponent[4:0] + `RFPS_PERIOD_SHIFT;

  // Registers the shifted product; an exponent above the legal range is
  // rejected upstream, so the shift never leaves the output width.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      delayPeriods <= {OUT_W{1'b0}};
    end else begin
      delayPeriods <= {{(OUT_W-18){1'b0}}, product} << shiftBy;
    end
  end

endmodule // rfps_delay_calc

// file: rtl/rfps_decoder.v
// Functional notes
// - Any reader protocol turns carrier on
// - Selection sets chains, field and antenna
// - Vicinity bits 5:4 select data rate
// - Vicinity bit 3: fixed delay or SOF
// - Vicinity bit 2: 100 or 10 percent
// - Vicinity bit 1: single or dual subcarrier
// - Vicinity bit 0: append transmit CRC
// - Type A bits 7:6 tx, 5:4 rx
// - Exponent accepted only up to 0x0E
// - Offset accepted only up to 0x7F
// - Type A absent or zero timing: default
// - Delay equals exponent, mantissa, offset formula
// - Type B rates, bit 0 CRC enable
// - Type B wait time, default 4096 periods
// - Type B guard count, LSB first, 1023
// - Type B minimum sync, default zero
// - Type B maximum sync, default 26
// - Success answers zero result, zero length
`timescale 1ns/1ps
`include "rfps_decoder_defs.vh"

module rfps_decoder #(
  parameter DELAY_W = 36  // Width of the delay count in carrier periods.
) (
  // Clock and reset.
  input  wire               clock,
  input  wire               sys_rst,
  // Avalon-MM register slave.
  input  wire [4:0]         avsAddress,
  input  wire               avsRead,
  input  wire               avsWrite,
  input  wire [31:0]        avsWriteData,
  input  wire [3:0]         avsByteEnable,
  output reg  [31:0]        avsReadData,
  output reg                avsWaitRequest,
  // Applied RF settings.
  output reg                rfFieldOn,
  output reg                antennaConnect,
  output reg  [1:0]         chainSelect,
  output reg  [1:0]         txRate,
  output reg  [1:0]         rxRate,
  output reg                waitForSof,
  output reg                modulation10,
  output reg                dualSubcarrier,
  output reg                crcAppend,
  output reg  [DELAY_W-1:0] frameDelayTime,
  output reg  [15:0]        responseGuardCount,
  output reg  [7:0]         minSyncCount,
  output reg  [7:0]         maxSyncCount,
  output reg                settingsValid
);

  // Parser states.
  localparam [2:0] ST_CODE  = 3'd0;
  localparam [2:0] ST_LEN   = 3'd1;
  localparam [2:0] ST_DATA  = 3'd2;
  localparam [2:0] ST_CALC  = 3'd3;
  localparam [2:0] ST_APPLY = 3'd4;

  // Guard count used when the host leaves out bytes 4 and 5.
  localparam [15:0] GUARD_DFLT = `RFPS_GUARD_DEFAULT;

  reg  [2:0]         stateQ;             // Parser state.
  reg  [7:0]         lenQ;               // Data length announced by the host.
  reg  [7:0]         cntQ;               // Data bytes taken so far.
  reg  [7:0]         parQ [0:8];         // Protocol byte and parameter bytes.
  reg  [7:0]         resultQ;            // Last answer code.
  reg                doneQ;              // Answer ready, cleared by reading it.
  wire               accept;             // Bus request taken this edge.
  wire               busy;               // Decode in progress, holds the bus.
  wire               cmdByteWrite;       // Command byte written by software.
  wire               responseRead;       // Answer register read.
  wire [DELAY_W-1:0] calcPeriods;        // Computed delay from the timing bytes.
  wire               timingGiven;        // Exponent, mantissa, offset present.
  reg  [7:0]         resultD;            // Answer code for the command.
  integer            i;                  // Reset loop index.

  // Returns parameter byte idx when the host sent it, else the default.
  function [7:0] optByte;
    input [7:0] len;
    input [7:0] idx;
    input [7:0] val;
    input [7:0] dflt;
    begin
      optByte = (len > idx + 8'h01) ? val : dflt;
    end
  endfunction

  // Checks a data length for the protocol held in the first byte.
  function lenOk;
    input [7:0] proto;
    input [7:0] len;
    begin
      if (proto == `RFPS_PROTO_TYPEA) begin
        lenOk = (len == 8'h02) || (len == 8'h05);
      end else if (proto == `RFPS_PROTO_TYPEB) begin
        lenOk = (len == 8'h02) || (len == 8'h05) || (len >= 8'h07 && len <= 8'h09);
      end else begin
        lenOk = (len == 8'h02);
      end
    end
  endfunction

  assign busy         = (stateQ == ST_CALC) || (stateQ == ST_APPLY);
  assign accept       = (avsRead || avsWrite) && avsWaitRequest && !busy;
  assign cmdByteWrite = accept && avsWrite && avsByteEnable[0]
                        && (avsAddress == `RFPS_OFF_CMD_BYTE);
  assign responseRead = accept && avsRead && (avsAddress == `RFPS_OFF_RESPONSE);
  assign timingGiven  = (lenQ >= 8'h05);

  // Delay arithmetic fed from the stored timing bytes, zero when omitted.
  rfps_delay_calc #(
    .OUT_W          (DELAY_W)
  ) u_delay (
    .clock          (clock),
    .sys_rst        (sys_rst),
    .timingExponent (optByte(lenQ, 8'h01, parQ[2], 8'h00)),
    .timingMantissa (optByte(lenQ, 8'h02, parQ[3], 8'h00)),
    .timingOffset   (optByte(lenQ, 8'h03, parQ[4], 8'h00)),
    .delayPeriods   (calcPeriods)
  );

  // Works out the answer code once the whole command is stored.
  always @* begin
    resultD = `RFPS_RES_OK;
    if (lenQ == 8'h00) begin
      // An empty command carries no protocol at all.
      resultD = `RFPS_RES_BAD_LEN;
    end else if (parQ[0] != `RFPS_PROTO_OFF && parQ[0] != `RFPS_PROTO_VIC
                 && parQ[0] != `RFPS_PROTO_TYPEA && parQ[0] != `RFPS_PROTO_TYPEB) begin
      // Protocols outside this block are refused.
      resultD = `RFPS_RES_BAD_PROTO;
    end else if (!lenOk(parQ[0], lenQ)) begin
      // A lone exponent without its mantissa is a length fault.
      resultD = `RFPS_RES_BAD_LEN;
    end else if (timingGiven && (parQ[2] > `RFPS_EXP_MAX)) begin
      // Reserved exponent values are not used.
      resultD = `RFPS_RES_BAD_LEN;
    end else if (timingGiven && (parQ[4] > `RFPS_OFFSET_MAX)) begin
      // Reserved offset values are not used.
      resultD = `RFPS_RES_BAD_LEN;
    end
  end

  // Bus handshake: a request is answered one edge after it is taken,
  // and waitrequest rises again on the edge at which it was seen low.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      avsWaitRequest <= 1'b1;
      avsReadData    <= 32'h00000000;
    end else begin
      avsWaitRequest <= !accept;
      if (accept && avsRead) begin
        // Register read decode; unmapped offsets read as zero.
        if (avsAddress == `RFPS_OFF_RESPONSE) begin
          avsReadData <= {15'h0000, doneQ, 8'h00, resultQ};
        end else if (avsAddress == `RFPS_OFF_STATUS) begin
          avsReadData <= {18'h00000, chainSelect, txRate, rxRate, settingsValid,
                          rfFieldOn, antennaConnect, waitForSof, modulation10,
                          dualSubcarrier, crcAppend, 1'b0};
        end else if (avsAddress == `RFPS_OFF_DELAY_LO) begin
          avsReadData <= frameDelayTime[31:0];
        end else if (avsAddress == `RFPS_OFF_DELAY_HI) begin
          avsReadData <= {{(64-DELAY_W){1'b0}}, frameDelayTime[DELAY_W-1:32]};
        end else if (avsAddress == `RFPS_OFF_GUARD) begin
          avsReadData <= {16'h0000, responseGuardCount};
        end else if (avsAddress == `RFPS_OFF_SYNC) begin
          avsReadData <= {16'h0000, maxSyncCount, minSyncCount};
        end else begin
          avsReadData <= 32'h00000000;
        end
      end
    end
  end

  // Command parser: code byte, length byte, then the data bytes.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= ST_CODE;
      lenQ   <= 8'h00;
      cntQ   <= 8'h00;
      for (i = 0; i < 9; i = i + 1) begin
        parQ[i] <= `RFPS_RST_BYTE;
      end
    end else begin
      case (stateQ)
        ST_CODE: begin
          // Bytes other than the select code are skipped.
          if (cmdByteWrite && avsWriteData[7:0] == `RFPS_CMD_SELECT) begin
            stateQ <= ST_LEN;
          end
        end
        ST_LEN: begin
          if (cmdByteWrite) begin
            lenQ   <= avsWriteData[7:0];
            cntQ   <= 8'h00;
            stateQ <= (avsWriteData[7:0] == 8'h00) ? ST_CALC : ST_DATA;
          end
        end
        ST_DATA: begin
          if (cmdByteWrite) begin
            // Bytes beyond the longest set are counted but not stored.
            if (cntQ < `RFPS_MAX_DATA) begin
              parQ[cntQ[3:0]] <= avsWriteData[7:0];
            end
            cntQ <= cntQ + 8'h01;
            if (cntQ + 8'h01 == lenQ) begin
              stateQ <= ST_CALC;
            end
          end
        end
        ST_CALC: begin
          // One edge for the delay arithmetic to settle.
          stateQ <= ST_APPLY;
        end
        default: begin
          stateQ <= ST_CODE;
        end
      endcase
    end
  end

  // Answer register; completion sets the flag and wins over a read clear.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      resultQ <= `RFPS_RES_OK;
      doneQ   <= 1'b0;
    end else begin
      if (stateQ == ST_APPLY) begin
        resultQ <= resultD;
        doneQ   <= 1'b1;
      end else if (responseRead) begin
        doneQ   <= 1'b0;
      end
    end
  end

  // Applies every decoded setting on one edge after a good command.
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rfFieldOn          <= 1'b0;
      antennaConnect     <= 1'b0;
      chainSelect        <= 2'b00;
      txRate             <= 2'b00;
      rxRate             <= 2'b00;
      waitForSof         <= 1'b0;
      modulation10       <= 1'b0;
      dualSubcarrier     <= 1'b0;
      crcAppend          <= 1'b0;
      frameDelayTime     <= `RFPS_RST_DELAY;
      responseGuardCount <= 16'h0000;
      minSyncCount       <= 8'h00;
      maxSyncCount       <= 8'h00;
      settingsValid      <= 1'b0;
    end else if (stateQ == ST_APPLY && resultD == `RFPS_RES_OK) begin
      // Chains follow the protocol code with no further host action.
      chainSelect        <= parQ[0][1:0];
      rfFieldOn          <= (parQ[0] != `RFPS_PROTO_OFF);
      antennaConnect     <= (parQ[0] != `RFPS_PROTO_OFF);
      settingsValid      <= 1'b1;
      waitForSof         <= 1'b0;
      modulation10       <= 1'b0;
      dualSubcarrier     <= 1'b0;
      crcAppend          <= 1'b0;
      responseGuardCount <= 16'h0000;
      minSyncCount       <= 8'h00;
      maxSyncCount       <= 8'h00;
      frameDelayTime     <= `RFPS_RST_DELAY;
      txRate             <= 2'b00;
      rxRate             <= 2'b00;
      case (parQ[0])
        `RFPS_PROTO_VIC: begin
          // One rate field serves both directions.
          txRate         <= parQ[1][`RFPS_VIC_RATE_HI:`RFPS_VIC_RATE_LO];
          rxRate         <= parQ[1][`RFPS_VIC_RATE_HI:`RFPS_VIC_RATE_LO];
          waitForSof     <= parQ[1][`RFPS_VIC_SOF_BIT];
          frameDelayTime <= `RFPS_VIC_DELAY_FC;
          modulation10   <= parQ[1][`RFPS_VIC_MOD_BIT];
          dualSubcarrier <= parQ[1][`RFPS_VIC_SUB_BIT];
          crcAppend      <= parQ[1][`RFPS_CRC_BIT];
        end
        `RFPS_PROTO_TYPEA: begin
          txRate <= parQ[1][`RFPS_TX_RATE_HI:`RFPS_TX_RATE_LO];
          rxRate <= parQ[1][`RFPS_RX_RATE_HI:`RFPS_RX_RATE_LO];
          // All-zero or missing timing keeps the standard delay.
          if (!timingGiven || {parQ[2], parQ[3], parQ[4]} == 24'h000000) begin
            frameDelayTime <= `RFPS_FDT_DEFAULT_FC;
          end else begin
            frameDelayTime <= calcPeriods;
          end
        end
        `RFPS_PROTO_TYPEB: begin
          txRate             <= parQ[1][`RFPS_TX_RATE_HI:`RFPS_TX_RATE_LO];
          rxRate             <= parQ[1][`RFPS_RX_RATE_HI:`RFPS_RX_RATE_LO];
          crcAppend          <= parQ[1][`RFPS_CRC_BIT];
          frameDelayTime     <= calcPeriods;
          responseGuardCount <= {optByte(lenQ, 8'h05, parQ[6], GUARD_DFLT[15:8]),
                                 optByte(lenQ, 8'h04, parQ[5], GUARD_DFLT[7:0])};
          minSyncCount       <= optByte(lenQ, 8'h06, parQ[7],
                                        `RFPS_MIN_SYNC_DEFAULT);
          maxSyncCount       <= optByte(lenQ, 8'h07, parQ[8],
                                        `RFPS_MAX_SYNC_DEFAULT);
        end
        default: begin
          // Field off: the single parameter byte is ignored.
          chainSelect <= 2'b00;
        end
      endcase
    end
  end

endmodule // rfps_decoder

// file: tb/rfps_decoder_assertions.sv
`timescale 1ns/1ps
// Port checker for the protocol selection decoder.
module rfps_decoder_assertions #(
  parameter DELAY_W = 36  // Width of the delay count.
) (
  // Clock and reset.
  input wire               clock,
  input wire               sys_rst,
  // Register bus.
  input wire               avsRead,
  input wire               avsWrite,
  input wire [4:0]         avsAddress,
  input wire [31:0]        avsReadData,
  input wire               avsWaitRequest,
  // Applied settings.
  input wire               rfFieldOn,
  input wire               antennaConnect,
  input wire [1:0]         chainSelect,
  input wire [1:0]         txRate,
  input wire [1:0]         rxRate,
  input wire               waitForSof,
  input wire               modulation10,
  input wire               dualSubcarrier,
  input wire               crcAppend,
  input wire [DELAY_W-1:0] frameDelayTime,
  input wire [15:0]        responseGuardCount,
  input wire [7:0]         minSyncCount,
  input wire [7:0]         maxSyncCount,
  input wire               settingsValid
);
  // All applied settings, so that a change anywhere is seen at once.
  wire [DELAY_W+44:0] setAll = {rfFieldOn, antennaConnect, chainSelect, txRate, rxRate,
    waitForSof, modulation10, dualSubcarrier, crcAppend, frameDelayTime,
    responseGuardCount, minSyncCount, maxSyncCount, settingsValid};

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_wait_one_cycle: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_after_req: assert property ($fell(avsWaitRequest) |-> $past(avsRead || avsWrite))
    else $error("waitrequest fell with no request");
  a_readdata_hold: assert property ($changed(avsReadData) |-> !avsWaitRequest && avsRead)
    else $error("read data moved outside a read");
  a_field_follows_chain: assert property (rfFieldOn == (chainSelect != 2'h0))
    else $error("carrier does not follow the selected chain");
  a_antenna_with_field: assert property (antennaConnect == rfFieldOn)
    else $error("antenna and carrier disagree");
  a_typea_no_crc: assert property (chainSelect == 2'h2 |-> !crcAppend)
    else $error("crc append set for Type A");
  a_vic_fixed_delay: assert property (chainSelect == 2'h1 && !waitForSof |->
    frameDelayTime == 4230)
    else $error("vicinity fixed delay wrong");
  a_settings_together: assert property (!$stable(setAll) |->
    $past(avsWrite && avsAddress == 5'h00, 2) || $past(avsWrite, 3))
    else $error("settings changed without a completed command");
  a_valid_stays: assert property (settingsValid |=> settingsValid)
    else $error("settings valid dropped");
endmodule // rfps_decoder_assertions

bind rfps_decoder rfps_decoder_assertions #(.DELAY_W(DELAY_W)) uChk (.clock, .sys_rst,
  .avsRead, .avsWrite, .avsAddress, .avsReadData, .avsWaitRequest, .rfFieldOn,
  .antennaConnect, .chainSelect, .txRate, .rxRate, .waitForSof, .modulation10,
  .dualSubcarrier, .crcAppend, .frameDelayTime, .responseGuardCount, .minSyncCount,
  .maxSyncCount, .settingsValid);

// file: tb/rfps_host_model.sv
`timescale 1ns/1ps
// Host controller: one register bus request at a time.
module rfps_host_model (
  // Clock.
  input  wire         clock,
  // Avalon-MM master side.
  output logic [4:0]  avsAddress    = 5'h00,
  output logic        avsRead       = 1'b0,
  output logic        avsWrite      = 1'b0,
  output logic [31:0] avsWriteData  = 32'h0,
  output logic [3:0]  avsByteEnable = 4'h0,
  input  wire  [31:0] avsReadData,
  input  wire         avsWaitRequest
);
  // Raises a request after an edge and holds it until waitrequest is seen low.
  task automatic xfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge clock);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= d;
    avsByteEnable <= be;
    do @(posedge clock); while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    // Released data shows a changed pattern, not the last value.
    avsWriteData <= ~d;
  endtask
endmodule // rfps_host_model

// file: tb/tb_rfps_decoder.sv
`timescale 1ns/1ps
// Drives protocol selections through the host and checks the applied settings.
module tb_rfps_decoder;
  logic        clock;                   // System clock.
  logic        sys_rst = 1'b1;          // Reset, held at start.
  wire  [4:0]  avsAddress;
  wire         avsRead, avsWrite, avsWaitRequest;
  wire  [31:0] avsWriteData, avsReadData;
  wire  [3:0]  avsByteEnable;
  wire         rfFieldOn, antennaConnect, waitForSof, modulation10;
  wire         dualSubcarrier, crcAppend, settingsValid;
  wire  [1:0]  chainSelect, txRate, rxRate;
  wire  [35:0] frameDelayTime;
  wire  [15:0] responseGuardCount;
  wire  [7:0]  minSyncCount, maxSyncCount;
  integer      err_count = 0, cmp_count = 0, seed = 82757, cycles = 0, i;
  logic [7:0]  cmd [0:8];               // Bytes of the next command.
  logic [7:0]  lenB [0:4] = '{8'h02, 8'h05, 8'h07, 8'h08, 8'h09};
  logic [7:0]  n;                       // Data length of the current command.
  logic [31:0] rd;                      // Last read data.
  logic [35:0] expDly;                  // Expected delay in carrier periods.

  rfps_decoder dut (.clock, .sys_rst, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable, .avsReadData, .avsWaitRequest, .rfFieldOn, .antennaConnect,
    .chainSelect, .txRate, .rxRate, .waitForSof, .modulation10, .dualSubcarrier,
    .crcAppend, .frameDelayTime, .responseGuardCount, .minSyncCount, .maxSyncCount,
    .settingsValid);
  rfps_host_model host (.clock, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable, .avsReadData, .avsWaitRequest);

  // Free running clock.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Cuts a hang short.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      report_and_stop;
    end
  end

  // Counts one comparison and reports a mismatch.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Delay from exponent, mantissa and offset, in carrier periods.
  function automatic logic [35:0] frame_delay_time(input logic [7:0] e, m, o);
    return (36'h1 << e) * (m + 36'h1) * (o + 36'h80) * 36'h20;
  endfunction

  // Sends a whole selection command and checks the answer.
  task automatic send(input logic [7:0] len, input logic [7:0] res);
    host.xfer(1'b1, 5'h00, 32'h02, 4'h1, rd);
    host.xfer(1'b1, 5'h00, {24'h0, len}, 4'h1, rd);
    for (int k = 0; k < len; k++) host.xfer(1'b1, 5'h00, {24'h0, cmd[k]}, 4'h1, rd);
    host.xfer(1'b0, 5'h04, 32'h0, 4'hf, rd);
    chk(rd[16:0], {1'b1, 8'h00, res});
  endtask

  // Verdict and end of run.
  task automatic report_and_stop;
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk({settingsValid, rfFieldOn, chainSelect, frameDelayTime}, 40'h0);
    // Vicinity: every low nibble and each defined rate.
    cmd[0] = 8'h01;
    for (i = 0; i < 24; i++) begin
      cmd[1] = {2'b00, 2'(i % 3), 4'(i)};
      send(8'h02, 8'h00);
      chk({chainSelect, rfFieldOn, antennaConnect, txRate, rxRate, waitForSof,
        modulation10, dualSubcarrier, crcAppend},
        {2'h1, 2'b11, cmd[1][5:4], cmd[1][5:0]});
      if (!cmd[1][3]) chk(frameDelayTime, 36'd4230);
    end
    // Type A rates with default timing, reserved bits random.
    cmd[0] = 8'h02;
    for (i = 0; i < 9; i++) begin
      cmd[1] = {2'(i / 3), 2'(i % 3), 4'($random(seed))};
      send(8'h02, 8'h00);
      chk({chainSelect, txRate, rxRate, crcAppend, frameDelayTime},
        {2'h2, cmd[1][7:4], 1'b0, 36'd1172});
    end
    // Type A timing: upper bounds, all zero, then random.
    for (i = 0; i < 12; i++) begin
      cmd[2] = 8'($unsigned($random(seed)) % 15);
      cmd[3] = 8'($random(seed));
      cmd[4] = 8'($random(seed)) & 8'h7f;
      if (i == 0) {cmd[2], cmd[3], cmd[4]} = 24'h0eff7f;
      if (i == 1) {cmd[2], cmd[3], cmd[4]} = 24'h0;
      send(8'h05, 8'h00);
      expDly = ({cmd[2], cmd[3], cmd[4]} == 24'h0) ? 36'd1172 : frame_delay_time(cmd[2], cmd[3], cmd[4]);
      chk(frameDelayTime, expDly);
    end
    // Refused commands leave the settings alone.
    cmd[2] = 8'h0f;
    send(8'h05, 8'h82);
    cmd[2] = 8'h00;
    cmd[4] = 8'h80;
    send(8'h05, 8'h82);
    send(8'h03, 8'h82);
    send(8'h00, 8'h82);
    cmd[0] = 8'h04;
    send(8'h02, 8'h83);
    chk({chainSelect, frameDelayTime}, {2'h2, expDly});
    // Field off, sent byte by byte with a pause and a dropped lane.
    host.xfer(1'b1, 5'h00, 32'h02, 4'h1, rd);
    host.xfer(1'b1, 5'h00, 32'h02, 4'h1, rd);
    host.xfer(1'b1, 5'h00, 32'h00, 4'h1, rd);
    repeat (4) @(posedge clock);
    chk({rfFieldOn, chainSelect}, 3'b110);
    host.xfer(1'b1, 5'h00, 32'hff, 4'h0, rd);
    host.xfer(1'b1, 5'h08, 32'hff, 4'hf, rd);
    host.xfer(1'b1, 5'h00, 32'ha5, 4'h1, rd);
    host.xfer(1'b0, 5'h04, 32'h0, 4'hf, rd);
    chk(rd[16:0], 17'h10000);
    chk({rfFieldOn, antennaConnect, chainSelect, crcAppend, settingsValid}, 6'h01);
    host.xfer(1'b0, 5'h08, 32'h0, 4'hf, rd);
    chk(rd, 32'h00000080);
    host.xfer(1'b0, 5'h1c, 32'h0, 4'hf, rd);
    chk(rd, 32'h0);
    // Type B with every accepted length and random fields.
    for (i = 0; i < 20; i++) begin
      for (int k = 1; k < 9; k++) cmd[k] = $random(seed);
      cmd[0] = 8'h03;
      cmd[2] = cmd[2] % 15;
      cmd[4] = cmd[4] & 8'h7f;
      n = lenB[i % 5];
      send(n, 8'h00);
      expDly = (n > 4) ? frame_delay_time(cmd[2], cmd[3], cmd[4]) : 36'd4096;
      chk({chainSelect, txRate, rxRate, crcAppend, rfFieldOn},
        {2'h3, cmd[1][7:4], cmd[1][0], 1'b1});
      chk(frameDelayTime, expDly);
      chk({responseGuardCount, minSyncCount, maxSyncCount}, {n > 6 ? {cmd[6], cmd[5]} :
        16'h03ff, n > 7 ? cmd[7] : 8'h00, n > 8 ? cmd[8] : 8'h1a});
    end
    host.xfer(1'b0, 5'h0c, 32'h0, 4'hf, rd);
    chk(rd, expDly[31:0]);
    // The last Type B command carried all nine bytes.
    host.xfer(1'b0, 5'h10, 32'h0, 4'hf, rd);
    chk(rd, {28'h0, expDly[35:32]});
    host.xfer(1'b0, 5'h14, 32'h0, 4'hf, rd);
    chk(rd, {16'h0, cmd[6], cmd[5]});
    host.xfer(1'b0, 5'h18, 32'h0, 4'hf, rd);
    chk(rd, {16'h0, cmd[8], cmd[7]});
    host.xfer(1'b0, 5'h08, 32'h0, 4'hf, rd);
    chk(rd, {18'h0, 2'h3, cmd[1][7:4], 4'he, 2'b00, cmd[1][0], 1'b0});
    report_and_stop;
  end
endmodule // tb_rfps_decoder
